/* File: logic/iam_consts.svh */
// Constants of the indirect address mapper
// Behaviour
// RULE_01: Port accesses redirect to pointer target; no storage
// RULE_02: Pointer at a port: read zero, write dropped
// RULE_03: Pointer is high byte concatenated with low byte
// RULE_04: Pointer 0x000-0xFFF maps straight onto banked memory
// RULE_05: Pointer 0x2000-0x29AF is linear view of bank RAM
// RULE_06: Linear increment past bank block enters next bank
// RULE_07: Unimplemented linear memory reads back 0x00
// RULE_08: Common bytes are excluded from linear region
// RULE_09: Pointer MSB set selects 15-bit flash address
// RULE_10: Flash read returns low eight bits only
// RULE_11: Writes aimed at flash never change it
// RULE_12: Flash access takes one extra instruction cycle
// RULE_13: Linear offset n: bank n/80, offset 0x20+n%80
// RULE_14: Banked pointer bits 11:7 bank, 6:0 byte
`ifndef IAM_CONSTS_SVH
`define IAM_CONSTS_SVH

`define IAM_BANKED_LAST 16'h0fff
`define IAM_LIN_BASE    16'h2000
`define IAM_LIN_LAST    16'h29af
`define IAM_LIN_BLOCK   12'h050
`define IAM_LIN_OFF     7'h20
`define IAM_PORT_LAST   7'h01
`define IAM_ZERO_BYTE   8'h00
`define IAM_FLASH_BIT   15
`define IAM_NUM_BANKS   5'h1f

`endif

/* File: logic/iam_pkg.sv */
// Types shared by the indirect address mapper
`default_nettype none
package iam_pkg;
	// Access request from the instruction datapath
	typedef struct packed {
		logic       valid;
		logic [7:0] ptr_high;
		logic [7:0] ptr_low;
		logic       we;
		logic [7:0] wdata;
	} iam_req_t;

	// Data RAM port
	typedef struct packed {
		logic        strobe;
		logic        we;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} iam_ram_t;

	// Access classes after decode
	typedef enum logic [1:0] {
		KIND_RAM,
		KIND_NULL,
		KIND_FLASH
	} iam_kind_t;
endpackage
`default_nettype wire

/* File: logic/iam_mapper.sv */
// Indirect address mapper: pointer decode, RAM and flash sequencing
`timescale 1ns/1ns
`default_nettype none
`include "iam_consts.svh"
module iam_mapper #(
	parameter logic [4:0] LIN_IMPL_BANKS = `IAM_NUM_BANKS
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	// Instruction datapath
	input  wire iam_pkg::iam_req_t req_i,
	output var  logic             busy_o,
	output var  logic             done_o,
	output var  logic [7:0]       rdata_o,
	// Data RAM
	output var  iam_pkg::iam_ram_t ram_o,
	input  wire logic [7:0]       ram_rdata_i,
	// Program flash
	output var  logic             flash_strobe_o,
	output var  logic [14:0]      flash_addr_o,
	input  wire logic [13:0]      flash_rdata_i
);
	import iam_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_EXTRA,
		ST_CAPTURE
	} iam_state_t;

	iam_state_t  state_reg;
	iam_state_t  state_next;
	iam_kind_t   kind_reg;
	iam_kind_t   dec_kind;
	logic        read_reg;
	logic [15:0] ptr;
	logic [11:0] dec_addr;
	logic [11:0] lin_n;
	logic [11:0] lin_bank;
	logic [11:0] lin_rem;
	logic        accept;
	logic        is_banked;
	logic        is_linear;
	logic        is_flash;

	////////////////////////////////////////////////////////////////////
	// Decode

	// Full 16-bit pointer from its two byte registers
	assign ptr = {req_i.ptr_high, req_i.ptr_low}; // [RULE_03]
	assign accept = (state_reg == ST_IDLE) && req_i.valid;
	assign is_flash = ptr[`IAM_FLASH_BIT]; // [RULE_09]
	assign is_banked = ptr <= `IAM_BANKED_LAST; // [RULE_04]
	assign is_linear = (ptr >= `IAM_LIN_BASE) && (ptr <= `IAM_LIN_LAST); // [RULE_05]
	assign lin_n = 12'(ptr - `IAM_LIN_BASE);
	// Constant divider; the range is small enough to fold into logic
	assign lin_bank = lin_n / `IAM_LIN_BLOCK; // [RULE_13]
	assign lin_rem = lin_n % `IAM_LIN_BLOCK; // [RULE_06]

	// Classify the access and form the RAM address
	always_comb begin
		dec_kind = KIND_NULL;
		dec_addr = 12'h000;
		if (is_flash) begin
			dec_kind = KIND_FLASH; // [RULE_09]
		end else if (is_banked) begin
			dec_addr = ptr[11:0]; // [RULE_04] [RULE_14]
			// A pointer aimed at a port sees nothing behind it
			if (ptr[6:0] > `IAM_PORT_LAST) begin
				dec_kind = KIND_RAM;
			end // [RULE_02]
		end else if (is_linear) begin
			// Only the per-bank block; common bytes are never hit
			dec_addr = {lin_bank[4:0], 7'(`IAM_LIN_OFF + lin_rem[6:0])}; // [RULE_08] [RULE_13]
			if (lin_bank[4:0] < LIN_IMPL_BANKS) begin
				dec_kind = KIND_RAM;
			end // [RULE_07]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer

	// Flash takes one cycle more than RAM
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (req_i.valid) begin
					state_next = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				state_next = (kind_reg == KIND_FLASH) ? ST_EXTRA : ST_CAPTURE; // [RULE_12]
			end
			ST_EXTRA: begin
				state_next = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// State and access class
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			kind_reg <= KIND_NULL;
			read_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				kind_reg <= dec_kind;
				read_reg <= !req_i.we;
			end
		end
	end

	// Busy from the taken request until the answer
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= (state_next != ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory ports

	// RAM strobe lasts one cycle; null accesses never touch memory
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ram_o <= '0;
		end else begin
			ram_o.strobe <= accept && (dec_kind == KIND_RAM); // [RULE_01] [RULE_02]
			if (accept) begin
				ram_o.we <= req_i.we;
				ram_o.addr <= dec_addr;
				ram_o.wdata <= req_i.wdata;
			end
		end
	end

	// Flash port is read only: writes are simply not issued
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			flash_strobe_o <= 1'b0;
			flash_addr_o <= 15'h0000;
		end else begin
			flash_strobe_o <= accept && is_flash && !req_i.we; // [RULE_11]
			if (accept) begin
				flash_addr_o <= ptr[14:0]; // [RULE_09]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Answer

	// Read data captured from the source, zero for null or write
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			done_o <= 1'b0;
			rdata_o <= `IAM_ZERO_BYTE;
		end else begin
			done_o <= (state_reg == ST_CAPTURE);
			if (state_reg == ST_CAPTURE) begin
				rdata_o <= `IAM_ZERO_BYTE; // [RULE_02] [RULE_07]
				if (read_reg && kind_reg == KIND_RAM) begin
					rdata_o <= ram_rdata_i; // [RULE_01]
				end else if (read_reg && kind_reg == KIND_FLASH) begin
					rdata_o <= flash_rdata_i[7:0]; // [RULE_10]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	a_ram_done_time: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_01]
		ram_o.strobe |-> !done_o ##1 !done_o ##1 done_o)
		else $error("RAM answer not two cycles after strobe");

	a_flash_extra_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_12]
		(accept && is_flash) |-> ##1 !done_o [*3] ##1 done_o)
		else $error("flash access lacks its extra cycle");

	a_flash_no_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_11]
		(accept && is_flash && req_i.we) |=> !flash_strobe_o && !ram_o.strobe)
		else $error("flash write reached a memory port");

	a_port_self_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_02]
		(accept && is_banked && ptr[6:0] <= `IAM_PORT_LAST)
		|=> !ram_o.strobe ##2 done_o && rdata_o == `IAM_ZERO_BYTE)
		else $error("port self reference not null");

	a_flash_addr_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_09]
		(accept && is_flash && !req_i.we) |=> flash_strobe_o && flash_addr_o == $past(ptr[14:0]))
		else $error("flash address wrong");

	a_banked_addr_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_04]
		(accept && is_banked && ptr[6:0] > `IAM_PORT_LAST)
		|=> ram_o.strobe && ram_o.addr == $past(ptr[11:0]))
		else $error("banked address wrong");

	a_linear_block_range: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_08]
		(accept && is_linear && dec_kind == KIND_RAM)
		|=> ram_o.addr[6:0] >= `IAM_LIN_OFF
		&& 12'(ram_o.addr[6:0]) < 12'(`IAM_LIN_OFF) + `IAM_LIN_BLOCK)
		else $error("linear access outside bank block");

	a_linear_bank_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_06]
		(accept && is_linear && dec_kind == KIND_RAM)
		|=> 12'(ram_o.addr[11:7]) * `IAM_LIN_BLOCK
		+ 12'(ram_o.addr[6:0] - `IAM_LIN_OFF) == $past(lin_n))
		else $error("linear offset not mapped to bank and byte");

	a_flash_low_byte: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_10]
		(state_reg == ST_CAPTURE && read_reg && kind_reg == KIND_FLASH)
		|=> done_o && rdata_o == $past(flash_rdata_i[7:0]))
		else $error("flash byte not returned");
endmodule
`default_nettype wire

/* File: bench/iam_far_model.sv */
// Model of the data RAM and program flash behind the mapper
`timescale 1ns/1ns
`default_nettype none
module iam_far_model (
	// Clock
	input  wire logic              mclk_i,
	// Data RAM side
	input  wire iam_pkg::iam_ram_t ram_i,
	output var  logic [7:0]        ram_rdata_o,
	// Flash side
	input  wire logic              flash_strobe_i,
	input  wire logic [14:0]       flash_addr_i,
	output var  logic [13:0]       flash_rdata_o
);
	import iam_pkg::*;
	logic [7:0] mem [0:4095];
	logic       fl_hit_reg;

	initial begin
		ram_rdata_o = 8'h00;
		flash_rdata_o = 14'h0000;
		fl_hit_reg = 1'b0;
	end

	//////////////////////////////////////////////////////////////////////
	// RAM answers one cycle after the strobe; other cycles scramble the bus
	always @(posedge mclk_i) begin
		if (ram_i.strobe && ram_i.we)
			mem[ram_i.addr] <= ram_i.wdata;
		if (ram_i.strobe && !ram_i.we)
			ram_rdata_o <= mem[ram_i.addr];
		else
			ram_rdata_o <= ~ram_rdata_o;
	end

	// Flash word two cycles after strobe; high bits differ from low byte
	always @(posedge mclk_i) begin
		fl_hit_reg <= flash_strobe_i;
		if (fl_hit_reg)
			flash_rdata_o <= {flash_addr_i[13:8], ~flash_addr_i[7:0]};
		else
			flash_rdata_o <= ~flash_rdata_o;
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the indirect address mapper
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
	import iam_pkg::*;
	logic        mclk_i, rst_n_i, busy_o, done_o, flash_strobe_o;
	logic [7:0]  rdata_o, ram_rdata_i;
	logic [14:0] flash_addr_o;
	logic [13:0] flash_rdata_i;
	logic [11:0] last_addr;
	iam_req_t    req_i;
	iam_ram_t    ram_o;
	int          failures, checks_done, n_ram, n_flash;

	// Bank count cut to four so unbacked linear banks can be reached
	iam_mapper #(.LIN_IMPL_BANKS(5'h04)) i_iam_mapper (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.req_i(req_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
		.ram_o(ram_o), .ram_rdata_i(ram_rdata_i), .flash_strobe_o(flash_strobe_o),
		.flash_addr_o(flash_addr_o), .flash_rdata_i(flash_rdata_i));
	iam_far_model i_iam_far_model (.mclk_i(mclk_i), .ram_i(ram_o), .ram_rdata_o(ram_rdata_i),
		.flash_strobe_i(flash_strobe_o), .flash_addr_i(flash_addr_o),
		.flash_rdata_o(flash_rdata_i));

	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	// Tally strobes seen by the memories
	always @(posedge mclk_i) begin
		if (ram_o.strobe === 1'b1) begin
			n_ram++;
			last_addr <= ram_o.addr;
		end
		if (flash_strobe_o === 1'b1)
			n_flash++;
	end

	task automatic close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One access, entered at a falling edge; checks data and latency
	task automatic acc(input logic [15:0] p, input logic w, input logic [7:0] wd,
		input logic [7:0] exp, input int lat);
		int n;
		req_i = '{1'b1, p[15:8], p[7:0], w, wd};
		@(negedge mclk_i);
		req_i.valid = 1'b0;
		`CHK(busy_o, 1'b1);
		// Count the take edge itself, so a RAM answer lands on 3 and flash on 4
		n = 1;
		while (done_o !== 1'b1 && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		if (n >= 20) begin
			failures++;
			close_out();
		end
		`CHK(rdata_o, exp);
		`CHK(busy_o, 1'b0);
		`CHK(n, lat);
	endtask

	task automatic t_banked;
		acc(16'h0123, 1'b1, 8'h5a, 8'h00, 3);
		`CHK(last_addr, 12'h123);
		acc(16'h0123, 1'b0, 8'h00, 8'h5a, 3);
	endtask

	task automatic t_port;
		int s;
		s = n_ram;
		acc(16'h0080, 1'b1, 8'ha5, 8'h00, 3);
		acc(16'h0f81, 1'b0, 8'h00, 8'h00, 3);
		`CHK(n_ram, s);
	endtask

	task automatic t_linear;
		acc(16'h204f, 1'b1, 8'h3c, 8'h00, 3);
		`CHK(last_addr, 12'h06f);
		acc(16'h2050, 1'b1, 8'hc3, 8'h00, 3);
		`CHK(last_addr, 12'h0a0);
		acc(16'h00a0, 1'b0, 8'h00, 8'hc3, 3);
		acc(16'h204f, 1'b0, 8'h00, 8'h3c, 3);
	endtask

	task automatic t_unimpl;
		int s;
		s = n_ram;
		acc(16'h2140, 1'b0, 8'h00, 8'h00, 3);
		acc(16'h29b0, 1'b1, 8'h11, 8'h00, 3);
		`CHK(n_ram, s);
	endtask

	task automatic t_flash;
		int s;
		acc(16'h8123, 1'b0, 8'h00, 8'hdc, 4);
		`CHK(flash_addr_o, 15'h0123);
		s = n_flash;
		acc(16'hff00, 1'b1, 8'h77, 8'h00, 4);
		`CHK(n_flash, s);
	endtask

	// Reset in mid access: everything drops, then a fresh access still works
	task automatic t_reset;
		req_i = '{1'b1, 8'h80, 8'h10, 1'b0, 8'h00};
		@(negedge mclk_i);
		req_i.valid = 1'b0;
		rst_n_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		`CHK(busy_o, 1'b0);
		`CHK(done_o, 1'b0);
		`CHK(flash_strobe_o, 1'b0);
		`CHK(rdata_o, 8'h00);
		rst_n_i = 1'b1;
		acc(16'h0123, 1'b0, 8'h00, 8'h5a, 3);
	endtask

	initial begin
		failures = 0;
		checks_done = 0;
		n_ram = 0;
		n_flash = 0;
		rst_n_i = 1'b0;
		req_i = '0;
		repeat (6) @(negedge mclk_i);
		rst_n_i = 1'b1;
		`CHK(done_o, 1'b0);
		t_banked();
		t_port();
		t_linear();
		t_unimpl();
		t_flash();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
